// File: shared/scd_pkg.sv
// Package with strap field layout, encodings and scan constants
package scd_pkg;

    localparam int STRAP_W = 4;

    // Field positions inside each 4-bit strap vector
    localparam int FLOW_BIT   = 0;
    localparam int ADRHI_BIT  = 3;
    localparam int MODE_LSB   = 1;
    localparam int MODE_MSB   = 2;
    localparam int ADV_LSB    = 0;
    localparam int ADV_MSB    = 1;
    localparam int SKEW_LSB   = 2;
    localparam int SKEW_MSB   = 3;
    localparam int TX_SKEW    = 2;
    localparam int RX_SKEW    = 3;
    localparam int AMODE_BIT  = 0;
    localparam int SPEED_LSB  = 1;
    localparam int SPEED_MSB  = 2;
    localparam int SIZE_BIT   = 3;
    localparam int LOW3_MSB   = 2;

    // Flow and interface mode encodings
    localparam logic       FLOW_COPPER   = 1'h0;
    localparam logic [1:0] MODE_RGMII    = 2'h0;
    localparam logic [1:0] MODE_SGMII    = 2'h1;
    localparam logic [1:0] MODE_RMII     = 2'h2;
    localparam logic [1:0] MODE_RTBI     = 2'h3;
    localparam logic [1:0] MODE_FX_PLAIN = 2'h0;
    localparam logic [1:0] MODE_FX_NEG   = 2'h1;

    // Advertise select encodings
    localparam logic [1:0] ADV_ALL       = 2'h0;
    localparam logic [1:0] ADV_LOW_HALF  = 2'h1;
    localparam logic [1:0] ADV_1000_ONLY = 2'h2;
    localparam logic [1:0] ADV_LOW_ONLY  = 2'h3;

    // Advertise vector bits: 10H 10F 100H 100F 1000H 1000F
    localparam logic [5:0] ADV_VEC_ALL   = 6'h3F;
    localparam logic [5:0] ADV_VEC_LHALF = 6'h35;
    localparam logic [5:0] ADV_VEC_1000  = 6'h30;
    localparam logic [5:0] ADV_VEC_LOW   = 6'h0F;
    localparam logic [5:0] ADV_VEC_NONE  = 6'h00;

    // Serial clock codes, values in kHz
    localparam logic [1:0]  SCL_100K = 2'h0;
    localparam logic [1:0]  SCL_400K = 2'h2;
    localparam logic [1:0]  SCL_1M   = 2'h1;
    localparam logic [1:0]  SCL_3M4  = 2'h3;
    localparam logic [11:0] KHZ_100  = 12'h064;
    localparam logic [11:0] KHZ_400  = 12'h190;
    localparam logic [11:0] KHZ_1000 = 12'h3E8;
    localparam logic [11:0] KHZ_3400 = 12'hD48;

    // Scan step: eight probes per size; log2 of step for code 00
    localparam int STEP_LOG_11 = 5;
    localparam int STEP_LOG_16 = 9;
    localparam int SCAN_PROBES = 8;
    localparam logic [15:0] SCAN_START = 16'h0000;

    // Settle time for strap and SDA sampling after reset release
    localparam int CLK_MHZ      = 200;
    localparam int SETTLE_NS    = 100;
    localparam int SETTLE_CYC   = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETTLE_W     = 8;

    // Skew delays in picoseconds
    localparam logic [10:0] SKEW_ON_PS  = 11'h5DC;
    localparam logic [10:0] SKEW_OFF_PS = 11'h000;

endpackage

// File: hw/scd_strap_config_decoder.sv
// Strap configuration decoder: captures straps once and decodes them
`timescale 1ns/10ps
module scd_strap_config_decoder
    import scd_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [3:0]   strap_pin_a_i,
    input  wire logic [3:0]   strap_pin_b_i,
    input  wire logic [3:0]   strap_pin_c_i,
    input  wire logic         sda_sense_i,
    input  wire logic         soft_reset_i,
    input  wire logic         record_found_i,
    input  wire logic         record_done_i,
    input  wire logic [2:0]   record_id_seen_i,
    input  wire logic [4:0]   record_phy_addr_i,
    input  wire logic [15:0]  mem_addr_i,
    input  wire logic [5:0]   scan_index_i,
    output logic              config_done_o,
    output logic              eeprom_present_o,
    output logic [4:0]        strap_phy_address_o,
    output logic              flow_converter_o,
    output logic [1:0]        mac_mode_o,
    output logic              mode_reserved_o,
    output logic              fiber_to_copper_negotiated_o,
    output logic              tx_delay_on_o,
    output logic              rx_delay_on_o,
    output logic [10:0]       tx_delay_ps_o,
    output logic [10:0]       rx_delay_ps_o,
    output logic [5:0]        adv_vector_o,
    output logic              eeprom_addr_width_sel_o,
    output logic [11:0]       scl_khz_o,
    output logic [3:0]        slave_addr_bits_o,
    output logic [2:0]        record_id_o,
    output logic              record_match_o,
    output logic [15:0]       scan_addr_o,
    output logic [15:0]       scan_limit_o,
    output logic              scan_last_o
);

    typedef enum logic [1:0] {ST_SETTLE, ST_CAPTURE, ST_HOLD} scd_state_t;

    scd_state_t             state;
    logic [SETTLE_W-1:0]    settle_cnt;
    logic [3:0]             a_meta, a_sync;
    logic [3:0]             b_meta, b_sync;
    logic [3:0]             c_meta, c_sync;
    logic                   sda_meta, sda_sync;
    logic [3:0]             vec_a, vec_b, vec_c;
    logic                   ee;

    // Two-flop synchronisers for pins coming from the board
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            a_meta   <= 4'h0;
            a_sync   <= 4'h0;
            b_meta   <= 4'h0;
            b_sync   <= 4'h0;
            c_meta   <= 4'h0;
            c_sync   <= 4'h0;
            sda_meta <= 1'h0;
            sda_sync <= 1'h0;
        end else begin
            a_meta   <= strap_pin_a_i;
            a_sync   <= a_meta;
            b_meta   <= strap_pin_b_i;
            b_sync   <= b_meta;
            c_meta   <= strap_pin_c_i;
            c_sync   <= c_meta;
            sda_meta <= sda_sense_i;
            sda_sync <= sda_meta;
        end
    end

    // Sequencer: wait for the strap levels to settle, capture once, hold.
    // Soft reset is deliberately not an input here so nothing recaptures.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state      <= ST_SETTLE;
            settle_cnt <= '0;
        end else begin
            unique case (state)
                ST_SETTLE: begin
                    if (settle_cnt == SETTLE_W'(SETTLE_CYC - 1)) begin
                        state <= ST_CAPTURE;
                    end
                    settle_cnt <= settle_cnt + SETTLE_W'(1);
                end
                ST_CAPTURE: begin
                    state <= ST_HOLD;
                end
                ST_HOLD: begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // Capture of the three vectors and the presence sense
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vec_a <= 4'h0;
            vec_b <= 4'h0;
            vec_c <= 4'h0;
            ee    <= 1'h0;
        end else if (state == ST_CAPTURE) begin
            vec_a <= a_sync;
            vec_b <= b_sync;
            vec_c <= c_sync;
            ee    <= sda_sync;
        end
    end

    // Decoded views, combinational from the held vectors, mem_addr_i and the record inputs
    logic [4:0]  next_phy_addr;
    logic        next_flow;
    logic [1:0]  next_mode;
    logic [1:0]  next_adv_sel;
    logic [5:0]  next_adv_vec;
    logic [11:0] next_scl;
    logic [1:0]  next_size;
    logic [3:0]  next_step_log;
    logic [15:0] next_limit;
    logic [15:0] next_slave;
    logic        next_match;

    always_comb begin
        next_phy_addr = {vec_b[ADRHI_BIT], vec_a};
        next_flow     = vec_b[FLOW_BIT];
        next_mode     = vec_b[MODE_MSB:MODE_LSB];
        next_adv_sel  = vec_c[ADV_MSB:ADV_LSB];
        next_adv_vec  = ADV_VEC_NONE;
        if (next_flow == FLOW_COPPER) begin
            unique case (next_adv_sel)
                ADV_ALL:       next_adv_vec = ADV_VEC_ALL;
                ADV_LOW_HALF:  next_adv_vec = ADV_VEC_LHALF;
                ADV_1000_ONLY: next_adv_vec = ADV_VEC_1000;
                ADV_LOW_ONLY:  next_adv_vec = ADV_VEC_LOW;
            endcase
        end
        // EEPROM view of the same straps
        unique case (vec_a[SPEED_MSB:SPEED_LSB])
            SCL_100K: next_scl = KHZ_100;
            SCL_400K: next_scl = KHZ_400;
            SCL_1M:   next_scl = KHZ_1000;
            SCL_3M4:  next_scl = KHZ_3400;
        endcase
        next_size = {vec_b[SIZE_BIT], vec_c[SIZE_BIT]};
        // Step doubles per size code; fixed probe count keeps scan time
        next_step_log = vec_a[AMODE_BIT]
            ? 4'(STEP_LOG_16) + 4'(next_size)
            : 4'(STEP_LOG_11) + 4'(next_size);
        next_limit = 16'(SCAN_PROBES) << next_step_log;
        // Slave bits OR memory bits only in 11-bit mode
        next_slave = {12'h000, vec_b[LOW3_MSB:0], 1'h0};
        if (!vec_a[AMODE_BIT]) begin
            next_slave = next_slave | {12'h000, mem_addr_i[10:8], 1'h0};
        end
        next_match = record_found_i &&
                     (record_id_seen_i == vec_c[LOW3_MSB:0]);
    end

    // Registered outputs: management address and flow parameters
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strap_phy_address_o          <= 5'h00;
            flow_converter_o             <= 1'h0;
            mac_mode_o                   <= MODE_RGMII;
            mode_reserved_o              <= 1'h0;
            fiber_to_copper_negotiated_o <= 1'h0;
            adv_vector_o                 <= ADV_VEC_NONE;
        end else if (ee) begin
            flow_converter_o             <= 1'h0;
            mac_mode_o                   <= MODE_RGMII;
            mode_reserved_o              <= 1'h0;
            fiber_to_copper_negotiated_o <= 1'h0;
            adv_vector_o                 <= ADV_VEC_NONE;
            // Address zero until record scan end, then matched record's address or vec_c low bits
            if (record_done_i && next_match) begin
                strap_phy_address_o <= record_phy_addr_i;
            end else if (record_done_i) begin
                strap_phy_address_o <= {2'h0, vec_c[LOW3_MSB:0]};
            end
        end else begin
            strap_phy_address_o <= next_phy_addr;
            flow_converter_o    <= next_flow;
            mac_mode_o          <= next_mode;
            mode_reserved_o     <= next_flow &&
                                   (next_mode != MODE_FX_PLAIN) &&
                                   (next_mode != MODE_FX_NEG);
            fiber_to_copper_negotiated_o <= next_flow &&
                                   (next_mode == MODE_FX_NEG);
            adv_vector_o        <= next_adv_vec;
        end
    end

    // RGMII delay selection, only meaningful in copper RGMII
    logic rgmii_sel;
    assign rgmii_sel = !ee && (next_flow == FLOW_COPPER) &&
                       (next_mode == MODE_RGMII);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_delay_on_o <= 1'h0;
            rx_delay_on_o <= 1'h0;
            tx_delay_ps_o <= SKEW_OFF_PS;
            rx_delay_ps_o <= SKEW_OFF_PS;
        end else begin
            tx_delay_on_o <= rgmii_sel && !vec_c[TX_SKEW];
            rx_delay_on_o <= rgmii_sel && !vec_c[RX_SKEW];
            tx_delay_ps_o <= (rgmii_sel && !vec_c[TX_SKEW]) ?
                             SKEW_ON_PS : SKEW_OFF_PS;
            rx_delay_ps_o <= (rgmii_sel && !vec_c[RX_SKEW]) ?
                             SKEW_ON_PS : SKEW_OFF_PS;
        end
    end

    // EEPROM parameters and scan address generation. Pointer reads are
    // left to the loader, which never sees scan_limit as a bound.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            eeprom_addr_width_sel_o <= 1'h0;
            scl_khz_o               <= KHZ_100;
            slave_addr_bits_o       <= 4'h0;
            record_id_o             <= 3'h0;
            record_match_o          <= 1'h0;
            scan_addr_o             <= SCAN_START;
            scan_limit_o            <= 16'h0000;
            scan_last_o             <= 1'h0;
        end else begin
            eeprom_addr_width_sel_o <= ee && vec_a[AMODE_BIT];
            scl_khz_o         <= next_scl;
            slave_addr_bits_o <= ee ? next_slave[3:0] : 4'h0;
            record_id_o       <= vec_c[LOW3_MSB:0];
            record_match_o    <= ee && next_match;
            scan_addr_o       <= SCAN_START +
                (16'(scan_index_i) << next_step_log);
            scan_limit_o      <= next_limit;
            scan_last_o       <= (scan_index_i == 6'(SCAN_PROBES - 1));
        end
    end

    // Done flag rises once the capture is held
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            config_done_o    <= 1'h0;
            eeprom_present_o <= 1'h0;
        end else begin
            config_done_o    <= (state == ST_HOLD);
            eeprom_present_o <= ee;
        end
    end

endmodule

// File: tb/scd_checker.sv
// Port assertions for the strap configuration decoder
`timescale 1ns/10ps
module scd_checker
    import scd_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic [5:0]  scan_index_i,
    input wire logic        record_done_i,
    input wire logic        config_done_o,
    input wire logic        eeprom_present_o,
    input wire logic [4:0]  strap_phy_address_o,
    input wire logic        flow_converter_o,
    input wire logic [1:0]  mac_mode_o,
    input wire logic        mode_reserved_o,
    input wire logic        tx_delay_on_o,
    input wire logic        rx_delay_on_o,
    input wire logic [10:0] tx_delay_ps_o,
    input wire logic [10:0] rx_delay_ps_o,
    input wire logic [15:0] scan_addr_o
);
    logic seen_done;

    // Remembers that the record scan has ended since reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seen_done <= 1'b0;
        end else if (record_done_i) begin
            seen_done <= 1'b1;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_done_hold;
        config_done_o |=> config_done_o;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("configuration done dropped");
    property p_held;
        config_done_o && !eeprom_present_o |=>
            $stable({strap_phy_address_o, flow_converter_o, mac_mode_o});
    endproperty
    a_held: assert property (p_held)
        else $error("captured parameters moved");
    property p_reserved;
        config_done_o |->
            mode_reserved_o == (flow_converter_o && mac_mode_o[1]);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved converter mode flag wrong");
    property p_tx_ps;
        config_done_o |->
            tx_delay_ps_o == (tx_delay_on_o ? SKEW_ON_PS : SKEW_OFF_PS);
    endproperty
    a_tx_ps: assert property (p_tx_ps)
        else $error("transmit delay value disagrees with flag");
    property p_rx_ps;
        config_done_o |->
            rx_delay_ps_o == (rx_delay_on_o ? SKEW_ON_PS : SKEW_OFF_PS);
    endproperty
    a_rx_ps: assert property (p_rx_ps)
        else $error("receive delay value disagrees with flag");
    property p_rgmii_only;
        config_done_o && (flow_converter_o || mac_mode_o != MODE_RGMII)
            |-> !tx_delay_on_o && !rx_delay_on_o;
    endproperty
    a_rgmii_only: assert property (p_rgmii_only)
        else $error("clock delay enabled outside copper RGMII");
    property p_addr_wait;
        config_done_o && eeprom_present_o && !seen_done
            |-> strap_phy_address_o == 5'h00;
    endproperty
    a_addr_wait: assert property (p_addr_wait)
        else $error("address not zero before record scan end");
    property p_scan_start;
        eeprom_present_o && $past(eeprom_present_o) &&
            $past(scan_index_i) == 6'h00 |-> scan_addr_o == SCAN_START;
    endproperty
    a_scan_start: assert property (p_scan_start)
        else $error("first probe not at address zero");
endmodule

bind scd_strap_config_decoder scd_checker u_scd_checker (.*);

// File: tb/scd_strap_model.sv
// Board model: strap components on the LED pins and the SDA pull
`timescale 1ns/10ps
module scd_strap_model (
    input  wire logic        clk_i,
    input  wire logic        done_i,
    input  wire logic [11:0] straps_i,
    input  wire logic        eeprom_i,
    output logic [3:0]       pin_a_o,
    output logic [3:0]       pin_b_o,
    output logic [3:0]       pin_c_o,
    output logic             sda_o
);
    logic [3:0] led_q = 4'h0;

    // LEDs start blinking once configured, so pins no longer show straps
    always_ff @(posedge clk_i) begin
        led_q <= done_i ? led_q + 4'h5 : 4'h0;
    end

    // One 4-bit vector per pin; pull-up on SDA only with a memory fitted
    assign pin_a_o = straps_i[11:8] ^ led_q;
    assign pin_b_o = straps_i[7:4] ^ led_q;
    assign pin_c_o = straps_i[3:0] ^ led_q;
    assign sda_o   = eeprom_i;
endmodule

// File: tb/tb.sv
// Self-checking bench for the strap configuration decoder
`timescale 1ns/10ps
module tb;
    import scd_pkg::*;
    typedef struct packed {logic [94:0] v; logic [94:0] m;} scd_note_t;
    logic        clk_i = 1'b0, rstn_i = 1'b0, soft_reset_i = 1'b0;
    logic        record_found_i = 1'b0, record_done_i = 1'b0, eeprom = 1'b0;
    logic [2:0]  record_id_seen_i = 3'h0, record_id_o;
    logic [4:0]  record_phy_addr_i = 5'h00, strap_phy_address_o;
    logic [15:0] mem_addr_i = 16'h0000, scan_addr_o, scan_limit_o;
    logic [5:0]  scan_index_i = 6'h00, adv_vector_o;
    logic [11:0] straps = 12'h000, scl_khz_o;
    logic [3:0]  strap_pin_a_i, strap_pin_b_i, strap_pin_c_i;
    logic [3:0]  slave_addr_bits_o;
    logic [10:0] tx_delay_ps_o, rx_delay_ps_o;
    logic [1:0]  mac_mode_o;
    logic        sda_sense_i, config_done_o, eeprom_present_o;
    logic        flow_converter_o, mode_reserved_o, tx_delay_on_o;
    logic        fiber_to_copper_negotiated_o, rx_delay_on_o;
    logic        eeprom_addr_width_sel_o, record_match_o, scan_last_o;
    logic [7:0]  lfsr = 8'hc7;
    int          bad_count = 0, compares = 0;
    scd_note_t   notes[$];
    event        look;

    scd_strap_config_decoder u_scd_strap_config_decoder (.*);
    scd_strap_model u_scd_strap_model (.clk_i(clk_i), .done_i(config_done_o),
        .straps_i(straps), .eeprom_i(eeprom), .pin_a_o(strap_pin_a_i),
        .pin_b_o(strap_pin_b_i), .pin_c_o(strap_pin_c_i), .sda_o(sda_sense_i));

    always #2.5 clk_i = ~clk_i;

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    // Expected outputs for board straps and the scan-side inputs
    function automatic scd_note_t exp_f(input logic [11:0] s, input logic e,
        input logic [15:0] mem, input logic [5:0] k, input logic f,
        input logic [2:0] id, input logic [4:0] ra, input logic dn);
        logic [3:0]  a, b, c;
        logic        fl, tx, rx, w, mt;
        logic [5:0]  adv;
        logic [11:0] scl;
        logic [4:0]  ad;
        logic [15:0] st;
        scd_note_t   n;
        a = s[11:8];
        b = s[7:4];
        c = s[3:0];
        fl = b[0];
        w = a[0];
        tx = !fl && b[2:1] == 2'h0 && !c[2];
        rx = !fl && b[2:1] == 2'h0 && !c[3];
        adv = c[1] ? (c[0] ? 6'h0f : 6'h30) : (c[0] ? 6'h35 : 6'h3f);
        scl = a[2] ? (a[1] ? 12'hd48 : 12'h190) : (a[1] ? 12'h3e8 : 12'h064);
        st = (w ? 16'h0200 : 16'h0020) << {b[3], c[3]};
        mt = f && id == c[2:0];
        ad = e ? (dn ? (mt ? ra : {2'h0, c[2:0]}) : 5'h00) : {b[3], a};
        n.v = {e, ad, fl, b[2:1], fl && b[2], fl && b[2:1] == 2'h1, tx, rx,
            tx ? 11'h5dc : 11'h000, rx ? 11'h5dc : 11'h000, fl ? 6'h00 : adv,
            w, scl, b[2:0] | (w ? 3'h0 : mem[10:8]), 1'b0, c[2:0], st * k,
            st << 3, k == 6'h07, mt};
        n.m = {6'h3f, {35{~e}}, {54{e}}};
        return n;
    endfunction

    task automatic give_verdict();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One hardware reset with new board straps, then three scan-side steps when e is set
    task automatic run_case(input logic [11:0] s, input logic e);
        int i;
        logic [15:0] mem;
        logic [5:0] k;
        logic [4:0] ra;
        logic [2:0] id;
        @(posedge clk_i);
        rstn_i <= 1'b0;
        straps <= s;
        eeprom <= e;
        {record_found_i, record_done_i, mem_addr_i, scan_index_i} <= '0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        notes.push_back(exp_f(s, e, 16'h0, 6'h0, 0, 3'h0, 5'h0, 0));
        for (i = 0; i < 100 && config_done_o !== 1'b1; i++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        soft_reset_i <= 1'b1;
        #1 -> look;
        for (i = 0; e && i < 3; i++) begin
            mem = {rnd(), rnd()};
            k = 6'(rnd() & 8'h07);
            ra = 5'(rnd() & 8'h1f);
            id = (i == 0) ? s[2:0] ^ 3'h1 : s[2:0];
            @(posedge clk_i);
            {mem_addr_i, scan_index_i, record_phy_addr_i} <= {mem, k, ra};
            {record_found_i, record_id_seen_i} <= {i != 2, id};
            record_done_i <= (i != 0);
            repeat (3) @(posedge clk_i);
            notes.push_back(exp_f(s, e, mem, k, i != 2, id, ra, i != 0));
            #1 -> look;
        end
        soft_reset_i <= 1'b0;
    endtask

    // Monitor: oldest expectation against the settled outputs
    initial forever begin
        scd_note_t n;
        logic [94:0] got;
        @(look);
        n = notes.pop_front();
        got = {eeprom_present_o, strap_phy_address_o, flow_converter_o,
            mac_mode_o, mode_reserved_o, fiber_to_copper_negotiated_o,
            tx_delay_on_o, rx_delay_on_o, tx_delay_ps_o, rx_delay_ps_o,
            adv_vector_o, eeprom_addr_width_sel_o, scl_khz_o,
            slave_addr_bits_o, record_id_o, scan_addr_o, scan_limit_o,
            scan_last_o, record_match_o};
        compares++;
        if ((got & n.m) !== (n.v & n.m)) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got & n.m,
                n.v & n.m);
        end
    end

    // Main sequence: every mode, flow, advertise and speed code
    initial begin
        logic [11:0] s;
        for (int i = 0; i < 32; i++) begin
            s = {rnd(), rnd()};
            if (!i[0]) {s[6:4], s[1:0]} = {i[2:1], i[3], i[2:1]};
            else {s[11:7], s[6:4]} = {1'b0, i[2:1], i[3], i[4], 3'h0};
            run_case(s, i[0]);
        end
        give_verdict();
    end

    // Watchdog cuts a hang short
    initial begin
        repeat (10000) @(posedge clk_i);
        bad_count++;
        give_verdict();
    end
endmodule
